// [src/qdsl_dev.sv]
// Converter end: samples the serial link and keeps four channel latches.
// Assumes link pins are asynchronous to SYS_CLK and much slower than it.
//
// How it works
// RL1 - Reset clears every latch to zero
// RL2 - Chip select high ignores sync and data
// RL3 - Sync fall starts frame, MSB first sampling
// RL4 - Sixteen bits or early sync rise transfers
// RL5 - Output updates at next rising clock edge
// RL6 - Three-wire or four-wire chip select use
// RL7 - Byte hosts send two bytes per frame
// RL8 - Top four bits control, low twelve code
// RL9 - Bit 12 picks fast or slow settling
// RL10 - Bit 13 requests channel power down
// RL11 - Power down bit disables that channel's amplifier
// RL12 - Bits 15 and 14 address the channel
// RL13 - Code is unsigned zero to 4095
// RL14 - Host holds sync through sixteenth bit
// RL15 - Host holds select past update event
// RL16 - Addresses 0 to 3 map A to D
// RL17 - Load strobe high freezes outputs except pin power-down
// RL18 - Hardware power-down pin overrides all channels
// RL19 - Frame alters only the addressed channel
// RL20 - Holding registers copied together by strobe
`timescale 1ns/1ps
module qdsl_dev (
  input wire logic SYS_CLK,
  input wire logic NRST,
  qdsl_if.dev LINK,
  output logic [qdsl_pkg::CODE_W-1:0] CODE_A,
  output logic [qdsl_pkg::CODE_W-1:0] CODE_B,
  output logic [qdsl_pkg::CODE_W-1:0] CODE_C,
  output logic [qdsl_pkg::CODE_W-1:0] CODE_D,
  output logic [qdsl_pkg::NUM_CHAN-1:0] FAST_SETTLE,
  output logic [qdsl_pkg::NUM_CHAN-1:0] AMP_ENABLE,
  output logic UPDATE_PULSE
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {IDLE, SHIFT, WAIT_RISE} qdsl_fsm_e;

  // Select, sync, clock and data pins pass syn then s3; prv only keeps the last s3 sample for edges
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [3:0] syn;
    logic [3:0] s3;
    logic [3:0] prv;
    qdsl_fsm_e fsm;
    logic [15:0] shreg;
    logic [4:0] cnt;
    logic [1:0] pend_chan;
    logic pend;
    qdsl_pkg::qdsl_chan_s [qdsl_pkg::NUM_CHAN-1:0] hold;
    qdsl_pkg::qdsl_chan_s [qdsl_pkg::NUM_CHAN-1:0] live;
    logic [qdsl_pkg::NUM_CHAN-1:0] amp;
    logic upd;
  } qdsl_dev_s;

  qdsl_dev_s st, next_st;
  logic cs_n, fs, sck, din, ld_n, pd_n;
  logic fs_fall, fs_rise, sck_fall, sck_rise;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Shifter and bit counter are sized for one frame of control bits plus code
  if (qdsl_pkg::FRAME_BITS != $bits(st.shreg) ||
      qdsl_pkg::CODE_W + 4 != qdsl_pkg::FRAME_BITS) begin : g_bad_frame
    $error("frame must be four control bits over the code");
  end

  // Two address bits pick one of the channel latches
  if (qdsl_pkg::NUM_CHAN != 2 ** $bits(st.pend_chan) ||
      qdsl_pkg::CHAN_HI_POS != qdsl_pkg::CHAN_LO_POS + 1) begin : g_bad_chan
    $error("channel count must match the two address bits");
  end

  // ----------------------------------------
  // Synchronised pins and edges
  // ----------------------------------------
  // Edge between the last two synchronised samples of one pin
  function automatic logic went_low(input logic prev_v, input logic cur_v);
    return prev_v && !cur_v;
  endfunction

  function automatic logic went_high(input logic prev_v, input logic cur_v);
    return !prev_v && cur_v;
  endfunction

  // Levels come from the second stage, edges also from prv; first stages feed nothing else
  assign cs_n = st.s3[0];
  assign fs = st.s3[1];
  assign sck = st.s3[2];
  assign din = st.s3[3];
  assign ld_n = st.s2[0];
  assign pd_n = st.s2[1];
  assign fs_fall = went_low(st.prv[1], fs);
  assign fs_rise = went_high(st.prv[1], fs);
  assign sck_fall = went_low(st.prv[2], sck);
  assign sck_rise = went_high(st.prv[2], sck);

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  function automatic qdsl_pkg::qdsl_chan_s decode_word(input logic [15:0] w);
    qdsl_pkg::qdsl_chan_s c;
    c.code = w[qdsl_pkg::CODE_W-1:0]; // see RL8 see RL13
    c.fast_settle_bit = w[qdsl_pkg::SPD_POS]; // see RL9
    c.power_down_bit = w[qdsl_pkg::PWR_POS]; // see RL10
    return c;
  endfunction

  // Address of a full frame sits in its top two bits
  function automatic logic [1:0] chan_of(input logic [15:0] w);
    return w[qdsl_pkg::CHAN_HI_POS:qdsl_pkg::CHAN_LO_POS]; // see RL12
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.upd = 1'b0;
    next_st.s1 = {LINK.hw_power_down_n, LINK.output_load_strobe_n};
    next_st.s2 = st.s1;
    next_st.syn = {LINK.sdata, LINK.sclk, LINK.frame_sync, LINK.cs_n};
    next_st.s3 = st.syn;
    next_st.prv = st.s3;

    // Drain last cycle's word first, so a new capture below always wins
    if (st.pend) begin
      // Short frame keeps bits right aligned; its address is whatever arrived
      next_st.hold[st.pend_chan] = decode_word(st.shreg); // see RL16 see RL19
      next_st.pend = 1'b0;
    end

    case (st.fsm)
      IDLE: begin
        if (!cs_n && fs_fall) begin // see RL2 see RL3 see RL6
          next_st.fsm = SHIFT;
          next_st.cnt = '0;
        end
      end

      SHIFT: begin
        if (cs_n) begin // see RL2
          // Select lost mid frame: the partial word is dropped
          next_st.fsm = IDLE;
        end else if (fs_rise) begin // see RL4
          next_st.pend = 1'b1;
          next_st.pend_chan = st.shreg[1:0];
          next_st.fsm = IDLE;
        end else if (sck_fall) begin // see RL3
          next_st.shreg = {st.shreg[14:0], din};
          next_st.cnt = st.cnt + 5'd1;
          if (st.cnt == 5'(qdsl_pkg::FRAME_BITS - 1)) begin // see RL4
            next_st.fsm = WAIT_RISE;
          end
        end
      end

      WAIT_RISE: begin
        // The update waits for the clock to rise again, not for the last fall
        if (sck_rise || fs_rise || cs_n) begin // see RL5 see RL4
          next_st.pend = 1'b1;
          next_st.pend_chan = chan_of(st.shreg);
          next_st.fsm = IDLE;
        end
      end

      default: begin
        next_st.fsm = IDLE;
      end
    endcase

    // Load strobe low copies every holding latch at once
    if (!ld_n) begin // see RL17 see RL20
      next_st.live = next_st.hold;
      next_st.upd = next_st.hold != st.live;
    end

    // Pin power-down wins over each channel's own bit
    for (int i = 0; i < qdsl_pkg::NUM_CHAN; i++) begin
      next_st.amp[i] = pd_n && !next_st.live[i].power_down_bit; // see RL11 see RL18
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '0; // see RL1
      // Synchronisers start at the idle pin levels so no false edge follows reset
      st.s1 <= 2'h3;
      st.s2 <= 2'h3;
      st.syn <= 4'h7;
      st.s3 <= 4'h7;
      st.prv <= 4'h7;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign CODE_A = st.live[0].code;
  assign CODE_B = st.live[1].code;
  assign CODE_C = st.live[2].code;
  assign CODE_D = st.live[3].code;
  assign AMP_ENABLE = st.amp;
  assign UPDATE_PULSE = st.upd;

  always_comb begin
    for (int i = 0; i < qdsl_pkg::NUM_CHAN; i++) begin
      FAST_SETTLE[i] = st.live[i].fast_settle_bit;
    end
  end
endmodule

// [src/qdsl_pkg.sv]
// Shared constants and types for the quad converter serial load link.
// Assumes both ends run on one 200 MHz system clock with active-low reset.
package qdsl_pkg;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CODE_W = 12;
  localparam int CHAN_HI_POS = 15;
  localparam int CHAN_LO_POS = 14;
  localparam int PWR_POS = 13;
  localparam int SPD_POS = 12;
  localparam int NUM_CHAN = 4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SYS_CLK_MHZ = 200;
  localparam int LINK_HALF_NS = 30;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int FIFO_DEPTH = 8;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic power_down_bit;
    logic fast_settle_bit;
  } qdsl_chan_s;
endpackage

// [src/qdsl_if.sv]
// Link wires between the host port and the converter load logic.
// Assumes the bench joins the two modports; all lines are one-way.
`timescale 1ns/1ps
interface qdsl_if;
  logic cs_n;
  logic frame_sync;
  logic sclk;
  logic sdata;
  logic output_load_strobe_n;
  logic hw_power_down_n;
  modport host (output cs_n, output frame_sync, output sclk, output sdata,
    output output_load_strobe_n, output hw_power_down_n);
  modport dev (input cs_n, input frame_sync, input sclk, input sdata,
    input output_load_strobe_n, input hw_power_down_n);
endinterface

// [src/qdsl_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock domain.
`timescale 1ns/1ps
module qdsl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = qdsl_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } qdsl_fptr_s;
  qdsl_fptr_s st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  assign in_ready = (st.wr - st.rd) != (AW+1)'(DEPTH);
  assign out_valid = st.wr != st.rd;
  assign out_data = mem[st.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

// [src/qdsl_host.sv]
// Host end: drains queued 16-bit words onto the serial link.
// Assumes the device samples pins with a faster clock; SCLK made by divider.
`timescale 1ns/1ps
module qdsl_host (
  input wire logic SYS_CLK,
  input wire logic NRST,
  qdsl_if.host LINK,
  input wire logic WORD_VALID,
  output logic WORD_READY,
  input wire logic [15:0] WORD_DATA,
  input wire logic BYTE_MODE,
  input wire logic USE_CS,
  input wire logic LOAD_N,
  input wire logic PD_N,
  output logic BUSY
);
  typedef enum logic [2:0] {H_IDLE, H_SEL, H_SYNC, H_LOW, H_HIGH, H_END} qdsl_hfsm_e;
  typedef struct packed {
    qdsl_hfsm_e fsm;
    logic [15:0] sh;
    logic [4:0] bits;
    logic [7:0] div;
    logic cs_n;
    logic fs;
    logic sck;
    logic sd;
    logic ld_n;
    logic pd_n;
  } qdsl_host_s;
  qdsl_host_s st, next_st;
  logic f_valid, f_ready, tick;
  logic [15:0] f_data;

  // ----------------------------------------
  // Word queue
  // ----------------------------------------
  qdsl_fifo #(.WIDTH(16), .DEPTH(qdsl_pkg::FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .in_valid(WORD_VALID),
    .in_ready(WORD_READY),
    .in_data(WORD_DATA),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  assign tick = st.div == 8'(qdsl_pkg::LINK_HALF_CYC - 1);
  assign f_ready = st.fsm == H_IDLE && f_valid;

  always_comb begin
    next_st = st;
    next_st.div = tick ? 8'h00 : st.div + 8'h01;
    next_st.ld_n = LOAD_N;
    next_st.pd_n = PD_N;
    case (st.fsm)
      H_IDLE: begin
        next_st.div = 8'h00;
        if (f_valid) begin
          next_st.sh = f_data;
          next_st.bits = '0;
          next_st.cs_n = 1'b0; // see RL2
          next_st.fsm = H_SEL;
        end
      end
      H_SEL: begin
        if (tick) begin
          next_st.fs = 1'b0; // see RL3 see RL7
          next_st.sd = st.sh[15];
          next_st.fsm = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tick) begin
          // Device samples on this falling edge
          next_st.sck = 1'b0;
          next_st.bits = st.bits + 5'd1;
          next_st.fsm = H_LOW;
        end
      end
      H_LOW: begin
        if (tick) begin
          next_st.sck = 1'b1;
          next_st.sh = {st.sh[14:0], 1'b0};
          next_st.sd = st.sh[14];
          if (st.bits == 5'(qdsl_pkg::FRAME_BITS)) begin
            next_st.fsm = H_END; // see RL14
          end else if (BYTE_MODE && st.bits == 5'd8) begin
            next_st.fsm = H_SYNC; // see RL7
          end else begin
            next_st.fsm = H_HIGH;
          end
        end
      end
      H_SYNC: begin
        // Gap between the two byte writes, sync held low
        if (tick) begin
          next_st.fsm = H_HIGH;
        end
      end
      H_END: begin
        if (tick) begin
          if (!st.fs) begin
            next_st.fs = 1'b1;
          end else begin
            next_st.cs_n = 1'b1; // see RL15
            next_st.fsm = H_IDLE;
          end
        end
      end
      default: begin
        next_st.fsm = H_IDLE;
      end
    endcase
    // Three-wire use keeps select low for good; frame sync alone delimits frames
    if (!USE_CS) begin
      next_st.cs_n = 1'b0; // see RL6
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st <= '0;
      st.cs_n <= 1'b1;
      st.fs <= 1'b1;
      st.sck <= 1'b1;
      st.ld_n <= 1'b1;
      st.pd_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign LINK.cs_n = st.cs_n;
  assign LINK.frame_sync = st.fs;
  assign LINK.sclk = st.sck;
  assign LINK.sdata = st.sd;
  assign LINK.output_load_strobe_n = st.ld_n;
  assign LINK.hw_power_down_n = st.pd_n;
  assign BUSY = st.fsm != H_IDLE;
endmodule

// [bench/qdsl_assertions.sv]
// Checker for the serial wires between the host end and the converter end.
// Assumes the bench instantiates it beside the link interface, one clock.
`timescale 1ns/1ps
module qdsl_assertions (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic cs_n,
  input wire logic frame_sync,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic output_load_strobe_n,
  input wire logic hw_power_down_n
);
  // ----------------
  // Link timing
  // ----------------
  int falls;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  sequence fs_fall; $fell(frame_sync); endsequence
  sequence sc_fall; $fell(sclk); endsequence
  // Counts bit edges so a short frame from the host shows up
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) falls <= 0;
    else if ($fell(frame_sync)) falls <= 0;
    else if ($fell(sclk)) falls <= falls + 1;
  end
  cs_setup_a: assert property (fs_fall |-> !cs_n && $past(!cs_n, 2))
    else $error("sync fell without select set up");
  sclk_framed_a: assert property (sc_fall |-> !frame_sync && !cs_n)
    else $error("clock fell outside a frame");
  first_bit_a: assert property (fs_fall |-> ##[2:12] sc_fall)
    else $error("no bit clock after sync fall");
  sclk_high_a: assert property ($rose(sclk) |=> sclk [*4])
    else $error("clock high too short");
  sclk_low_a: assert property (sc_fall |=> !sclk [*4])
    else $error("clock low too short");
  data_hold_a: assert property (sc_fall |=> $stable(sdata))
    else $error("data moved at sampling edge");
  full_word_a: assert property ($rose(frame_sync) |-> falls == 16)
    else $error("sync rose before sixteen bits");
  sync_pulse_a: assert property ($rose(frame_sync) |=> frame_sync [*3])
    else $error("sync high too short");
  cs_hold_a: assert property ($rose(cs_n) |-> $past(frame_sync, 2) && $past(sclk, 2))
    else $error("select released before update");
endmodule

// [bench/test_quad_dac_serial_load.sv]
// Bench: host end feeds a converter end; a second converter end is driven
// by the bench itself to break host rules. Assumes the design's 6-cycle half period.
`timescale 1ns/1ps
module test_quad_dac_serial_load;
  // ----------------
  // Harness
  // ----------------
  logic clk = 0, nrst = 0, vld = 0, bmode = 0, ld_n = 0, pd_n = 1, refused = 0, use_cs = 1;
  logic [15:0] wd = 16'h0000;
  logic rdy, busy, upd;
  logic [11:0] ca, cb, cc, cd, c2b;
  logic [3:0] fast, amp;
  logic [15:0] hold [4], live [4];
  int num_errors = 0, samples_checked = 0, cycles = 0, seed = 32'h33f5;
  int upd_seen = 0, upd_base = 0, exp_upd = 0;
  qdsl_if link ();
  qdsl_if link2 ();
  always #2.5 clk = ~clk;
  qdsl_host i_qdsl_host (.SYS_CLK(clk), .NRST(nrst), .LINK(link), .WORD_VALID(vld),
    .WORD_READY(rdy), .WORD_DATA(wd), .BYTE_MODE(bmode), .USE_CS(use_cs),
    .LOAD_N(ld_n), .PD_N(pd_n), .BUSY(busy));
  qdsl_dev i_qdsl_dev (.SYS_CLK(clk), .NRST(nrst), .LINK(link), .CODE_A(ca), .CODE_B(cb),
    .CODE_C(cc), .CODE_D(cd), .FAST_SETTLE(fast), .AMP_ENABLE(amp), .UPDATE_PULSE(upd));
  qdsl_dev i_qdsl_dev_2 (.SYS_CLK(clk), .NRST(nrst), .LINK(link2), .CODE_A(), .CODE_B(c2b),
    .CODE_C(), .CODE_D(), .FAST_SETTLE(), .AMP_ENABLE(), .UPDATE_PULSE());
  qdsl_assertions i_qdsl_assertions (.SYS_CLK(clk), .NRST(nrst), .cs_n(link.cs_n),
    .frame_sync(link.frame_sync), .sclk(link.sclk), .sdata(link.sdata),
    .output_load_strobe_n(link.output_load_strobe_n),
    .hw_power_down_n(link.hw_power_down_n));
  // A hang still ends in the closing report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (upd === 1'b1) begin
      upd_seen <= upd_seen + 1;
    end
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_all();
    logic [11:0] c [4];
    c = '{ca, cb, cc, cd};
    for (int i = 0; i < 4; i++) begin
      chk("code", c[i], live[i][11:0]);
      chk("fast", fast[i], live[i][12]);
      chk("amp", amp[i], pd_n & ~live[i][13]);
    end
  endtask
  // Pushes one word; the model follows at the accepting edge
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    vld <= 1;
    wd <= w;
    bmode <= 1'($random(seed));
    use_cs <= 1'($random(seed));
    @(negedge clk);
    while (rdy !== 1'b1) begin
      refused = 1;
      @(negedge clk);
    end
    @(posedge clk);
    vld <= 0;
    hold[w[15:14]] = w;
    if (!ld_n) live = hold;
  endtask
  // Waits until the link has been idle long enough for every update to land
  task automatic settle();
    int idle;
    idle = 0;
    for (int n = 0; n < 6000 && idle < 30; n++) begin
      @(negedge clk);
      idle = (busy === 1'b0) ? idle + 1 : 0;
    end
  endtask
  // Frame made by the bench on the second link, 64 ns bit clock
  task automatic bang(input logic [15:0] w, input logic cs, input logic [11:0] mid);
    link2.cs_n = cs;
    #32 link2.frame_sync = 0;
    for (int i = 15; i >= 0; i--) begin
      link2.sdata = w[i];
      #32 link2.sclk = 0;
      #32 if (i > 0) link2.sclk = 1;
    end
    #200 chk("code2 before rise", c2b, mid);
    link2.sclk = 1;
    #32 link2.frame_sync = 1;
    link2.sdata = ~w[0];
    #100;
  endtask
  // ----------------
  // Tests
  // ----------------
  initial begin
    link2.cs_n = 1;
    link2.frame_sync = 1;
    link2.sclk = 1;
    link2.sdata = 0;
    link2.output_load_strobe_n = 0;
    link2.hw_power_down_n = 1;
    hold = '{default: 16'h0000};
    live = hold;
    repeat (5) @(posedge clk);
    nrst <= 1;
    repeat (8) @(negedge clk);
    check_all();
    $display("test reset done");
    foreach (hold[i]) begin
      send({2'(i), 2'(3 - i), 12'(4095 - i)});
      settle();
      check_all();
    end
    for (int i = 0; i < 10; i++) begin
      send(16'($random(seed)));
      settle();
      check_all();
    end
    $display("test words done");
    @(posedge clk);
    pd_n <= 0;
    settle();
    check_all();
    @(posedge clk);
    pd_n <= 1;
    settle();
    check_all();
    $display("test power done");
    @(posedge clk);
    ld_n <= 1;
    upd_base = upd_seen;
    for (int i = 0; i < 10; i++) send(16'($random(seed)));
    chk("ready refused", refused, 1'b1);
    settle();
    check_all();
    chk("update frozen", 16'(upd_seen - upd_base), 16'h0000);
    @(posedge clk);
    ld_n <= 0;
    exp_upd = (hold != live) ? 1 : 0;
    upd_base = upd_seen;
    live = hold;
    settle();
    check_all();
    chk("update once", 16'(upd_seen - upd_base), 16'(exp_upd));
    $display("test load done");
    bang(16'h5abc, 1'b1, 12'h000);
    chk("code2 ignored", c2b, 12'h000);
    bang(16'h5abc, 1'b0, 12'h000);
    chk("code2 loaded", c2b, 12'habc);
    $display("test second end done");
    stop_test();
  end
endmodule
